// file: core/rgctl_pkg.sv
// Package for the regulator control logic: channel counts, code layout,
// reset values and timing counts. Assumes a 100 MHz core clock.
package rgctl_pkg;
	localparam int RGCTL_NUM_BUCK = 4;
	localparam int RGCTL_NUM_LDO = 8;
	localparam int RGCTL_CODE_W = 6;
	localparam int RGCTL_MV_W = 13;
	localparam int RGCTL_RANGE_HI = 5;
	localparam int RGCTL_RANGE_LO = 3;
	localparam int RGCTL_STEP_HI = 2;
	localparam int RGCTL_STEP_LO = 0;
	// Decoded voltage endpoints in millivolts
	localparam logic [12:0] RGCTL_MV_MIN = 13'h0258;
	localparam logic [12:0] RGCTL_MV_MAX = 13'h0F3C;
	// Built-in default codes (values of this build)
	localparam logic [5:0] RGCTL_BUCK_DEF_CODE = 6'h18;
	localparam logic [5:0] RGCTL_LDO_DEF_CODE = 6'h24;
	// Soft-start ramp
	localparam int RGCTL_SS_TIME_NS = 400000;
	localparam int RGCTL_CLK_PERIOD_NS = 10;
	localparam int RGCTL_SS_CYCLES = RGCTL_SS_TIME_NS / RGCTL_CLK_PERIOD_NS;
	localparam int RGCTL_SS_W = 16;
	// Base millivolts and step of each coarse range
	function automatic logic [12:0] rgctl_decode_mv(input logic [5:0] code);
		logic [12:0] base;
		logic [12:0] step;
		base = 13'h0000;
		step = 13'h0000;
		case (code[RGCTL_RANGE_HI:RGCTL_RANGE_LO])
			3'h0: begin base = 13'h0258; step = 13'h0019; end
			3'h1: begin base = 13'h0320; step = 13'h0019; end
			3'h2: begin base = 13'h03E8; step = 13'h0019; end
			3'h3: begin base = 13'h04B0; step = 13'h0032; end
			3'h4: begin base = 13'h0640; step = 13'h0032; end
			3'h5: begin base = 13'h07D0; step = 13'h0032; end
			3'h6: begin base = 13'h0960; step = 13'h0064; end
			default: begin base = 13'h0C80; step = 13'h0064; end
		endcase
		return 13'(base + step * 13'(code[RGCTL_STEP_HI:RGCTL_STEP_LO]));
	endfunction : rgctl_decode_mv
endpackage : rgctl_pkg

// file: core/rgctl_softstart.sv
// One step-down soft-start timer: runs for the ramp time after enable
// or after a fault clears. Assumes synchronous inputs.
`timescale 1ns/1ps
module rgctl_softstart
	import rgctl_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Control
	input wire logic i_enable,
	input wire logic i_fault,
	// Status
	output logic o_ramping
);
	typedef struct packed {
		logic en_prev;
		logic flt_prev;
		logic ramping;
		logic [RGCTL_SS_W-1:0] cnt;
	} rgctl_ss_s;
	rgctl_ss_s st_ff;
	rgctl_ss_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.en_prev = i_enable;
		nxt_st.flt_prev = i_fault;
		if (!i_enable) begin
			nxt_st.ramping = 1'b0;
			nxt_st.cnt = '0;
		end else if ((!st_ff.en_prev) || (st_ff.flt_prev && !i_fault)) begin
			nxt_st.ramping = 1'b1;
			nxt_st.cnt = RGCTL_SS_W'(RGCTL_SS_CYCLES - 1);
		end else if (st_ff.ramping) begin
			if (st_ff.cnt == '0) begin
				nxt_st.ramping = 1'b0;
			end else begin
				nxt_st.cnt = RGCTL_SS_W'(st_ff.cnt - 1'b1);
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_ramping = st_ff.ramping;
endmodule : rgctl_softstart

// file: core/rgctl_irq_chan.sv
// Fault interrupt request of one regulator channel: latched on a fall
// out of regulation, released after recovery and a status read.
`timescale 1ns/1ps
module rgctl_irq_chan (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Channel status
	input wire logic i_enable,
	input wire logic i_power_good,
	input wire logic i_fault_irq_unmask,
	input wire logic i_status_read,
	// Request
	output logic o_pending
);
	typedef struct packed {
		logic pending;
		logic read_seen;
	} rgctl_irq_s;
	rgctl_irq_s st_ff;
	rgctl_irq_s nxt_st;
	logic fault;
	logic recovered;

	always_comb begin
		fault = i_enable && !i_power_good;
		recovered = !i_enable || i_power_good;
		nxt_st = st_ff;
		if (st_ff.pending && i_status_read) begin
			nxt_st.read_seen = 1'b1;
		end
		if (st_ff.pending && recovered && (st_ff.read_seen || i_status_read)) begin
			nxt_st.pending = 1'b0;
			nxt_st.read_seen = 1'b0;
		end
		// A new fault wins over release
		if (i_fault_irq_unmask && fault) begin
			nxt_st.pending = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_pending = st_ff.pending;
endmodule : rgctl_irq_chan

// file: core/rgctl_top.sv
// Regulator control logic: voltage codes, enables, power-good status,
// fault interrupt and LDO discharge. Register writes arrive as strobes
// from an outside I2C slave; analog comparators feed power-good levels.
// Summary of operation
// - Buck 2-4 use bank A while select pin low, bank B while high.
// - Bucks load built-in default code at power-up before any write.
// - Code bits 5:3 pick range, 2:0 step; 0.600 V to 3.900 V.
// - LDOs start at default code, then take written codes, same mapping.
// - Each buck follows its host-written enable bit.
// - Each LDO follows its host-written enable bit.
// - Buck power-good bit reads 0 while output below threshold.
// - Unmasked enabled buck dropping below threshold raises an interrupt.
// - Interrupt held until regulator off or recovered and status read.
// - LDO discharge active while disabled only when its discharge bit is 1.
// - Buck soft-start ramp of 400 us on enable or fault recovery.
`timescale 1ns/1ps
module rgctl_top
	import rgctl_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Buck code writes, one strobe per channel and bank
	input wire logic [RGCTL_NUM_BUCK-1:0] i_buck_bank_a_wr,
	input wire logic [RGCTL_NUM_BUCK-1:0] i_buck_bank_b_wr,
	input wire logic [RGCTL_CODE_W-1:0] i_wr_code,
	// LDO code writes
	input wire logic [RGCTL_NUM_LDO-1:0] i_ldo_code_wr,
	// Control bits
	input wire logic [RGCTL_NUM_BUCK-1:0] i_buck_enable,
	input wire logic [RGCTL_NUM_LDO-1:0] i_ldo_enable,
	input wire logic [RGCTL_NUM_BUCK-1:0] i_fault_irq_unmask,
	input wire logic [RGCTL_NUM_LDO-1:0] i_output_discharge_enable,
	input wire logic [RGCTL_NUM_BUCK-1:0] i_voltage_bank_select_pin,
	// Power-good comparators and status read strobes
	input wire logic [RGCTL_NUM_BUCK-1:0] i_buck_power_good,
	input wire logic [RGCTL_NUM_BUCK-1:0] i_status_read,
	// Buck outputs
	output logic [RGCTL_NUM_BUCK*RGCTL_CODE_W-1:0] o_buck_output_voltage_code,
	output logic [RGCTL_NUM_BUCK*RGCTL_MV_W-1:0] o_buck_target_mv,
	output logic [RGCTL_NUM_BUCK-1:0] o_buck_on,
	output logic [RGCTL_NUM_BUCK-1:0] o_buck_soft_start,
	output logic [RGCTL_NUM_BUCK-1:0] o_buck_power_good,
	// LDO outputs
	output logic [RGCTL_NUM_LDO*RGCTL_CODE_W-1:0] o_ldo_output_voltage_code,
	output logic [RGCTL_NUM_LDO*RGCTL_MV_W-1:0] o_ldo_target_mv,
	output logic [RGCTL_NUM_LDO-1:0] o_ldo_on,
	output logic [RGCTL_NUM_LDO-1:0] o_ldo_discharge,
	// Interrupt
	output logic o_host_irq_out_n
);
	typedef struct packed {
		logic [RGCTL_NUM_BUCK-1:0][RGCTL_CODE_W-1:0] bank_a;
		logic [RGCTL_NUM_BUCK-1:0][RGCTL_CODE_W-1:0] bank_b;
		logic [RGCTL_NUM_LDO-1:0][RGCTL_CODE_W-1:0] ldo_code;
		logic [RGCTL_NUM_BUCK-1:0][RGCTL_CODE_W-1:0] buck_out;
		logic [RGCTL_NUM_BUCK-1:0][RGCTL_MV_W-1:0] buck_mv;
		logic [RGCTL_NUM_LDO-1:0][RGCTL_MV_W-1:0] ldo_mv;
		logic [RGCTL_NUM_BUCK-1:0] buck_on;
		logic [RGCTL_NUM_BUCK-1:0] buck_ss;
		logic [RGCTL_NUM_BUCK-1:0] buck_pg;
		logic [RGCTL_NUM_LDO-1:0] ldo_on;
		logic [RGCTL_NUM_LDO-1:0] ldo_dis;
		logic irq_n;
	} rgctl_state_s;

	rgctl_state_s st_ff;
	rgctl_state_s nxt_st;
	logic [RGCTL_NUM_BUCK-1:0] ss_ramping;
	logic [RGCTL_NUM_BUCK-1:0] irq_pending;
	logic [RGCTL_NUM_BUCK-1:0] buck_fault;

	// Per-buck soft-start and interrupt request
	genvar g;
	generate
		for (g = 0; g < RGCTL_NUM_BUCK; g++) begin : g_buck
			assign buck_fault[g] = i_buck_enable[g] && !i_buck_power_good[g];
			rgctl_softstart u_softstart (
				.i_clock(i_clock),
				.i_arst_n(i_arst_n),
				.i_enable(i_buck_enable[g]),
				.i_fault(buck_fault[g]),
				.o_ramping(ss_ramping[g])
			);
			rgctl_irq_chan u_irq_chan (
				.i_clock(i_clock),
				.i_arst_n(i_arst_n),
				.i_enable(i_buck_enable[g]),
				.i_power_good(i_buck_power_good[g]),
				.i_fault_irq_unmask(i_fault_irq_unmask[g]),
				.i_status_read(i_status_read[g]),
				.o_pending(irq_pending[g])
			);
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		for (int i = 0; i < RGCTL_NUM_BUCK; i++) begin
			if (i_buck_bank_a_wr[i]) begin
				nxt_st.bank_a[i] = i_wr_code;
			end
			if (i_buck_bank_b_wr[i]) begin
				nxt_st.bank_b[i] = i_wr_code;
			end
			// First buck has no select pin and always uses bank A
			if (i != 0 && i_voltage_bank_select_pin[i]) begin
				nxt_st.buck_out[i] = nxt_st.bank_b[i];
			end else begin
				nxt_st.buck_out[i] = nxt_st.bank_a[i];
			end
			nxt_st.buck_mv[i] = rgctl_decode_mv(nxt_st.buck_out[i]);
		end
		nxt_st.buck_on = i_buck_enable;
		nxt_st.buck_ss = ss_ramping;
		nxt_st.buck_pg = i_buck_power_good;
		for (int j = 0; j < RGCTL_NUM_LDO; j++) begin
			if (i_ldo_code_wr[j]) begin
				nxt_st.ldo_code[j] = i_wr_code;
			end
			nxt_st.ldo_mv[j] = rgctl_decode_mv(nxt_st.ldo_code[j]);
		end
		nxt_st.ldo_on = i_ldo_enable;
		nxt_st.ldo_dis = ~i_ldo_enable & i_output_discharge_enable;
		nxt_st.irq_n = ~(|irq_pending);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
			st_ff.bank_a <= {RGCTL_NUM_BUCK{RGCTL_BUCK_DEF_CODE}};
			st_ff.bank_b <= {RGCTL_NUM_BUCK{RGCTL_BUCK_DEF_CODE}};
			st_ff.buck_out <= {RGCTL_NUM_BUCK{RGCTL_BUCK_DEF_CODE}};
			st_ff.ldo_code <= {RGCTL_NUM_LDO{RGCTL_LDO_DEF_CODE}};
			st_ff.irq_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_buck_output_voltage_code = st_ff.buck_out;
	assign o_buck_target_mv = st_ff.buck_mv;
	assign o_buck_on = st_ff.buck_on;
	assign o_buck_soft_start = st_ff.buck_ss;
	assign o_buck_power_good = st_ff.buck_pg;
	assign o_ldo_output_voltage_code = st_ff.ldo_code;
	assign o_ldo_target_mv = st_ff.ldo_mv;
	assign o_ldo_on = st_ff.ldo_on;
	assign o_ldo_discharge = st_ff.ldo_dis;
	assign o_host_irq_out_n = st_ff.irq_n;
endmodule : rgctl_top

// file: verif/rgctl_top_sva.sv
// Assertions on the regulator control top level ports.
// Assumes one clock domain; bound to every instance below.
`timescale 1ns/1ps
module rgctl_top_sva
	import rgctl_pkg::*;
(
	// Clock, reset and inputs
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [3:0] i_buck_bank_a_wr,
	input wire logic [3:0] i_buck_bank_b_wr,
	input wire logic [5:0] i_wr_code,
	input wire logic [3:0] i_buck_enable,
	input wire logic [3:0] i_fault_irq_unmask,
	input wire logic [3:0] i_voltage_bank_select_pin,
	input wire logic [3:0] i_buck_power_good,
	// Outputs
	input wire logic [23:0] o_buck_output_voltage_code,
	input wire logic [51:0] o_buck_target_mv,
	input wire logic [3:0] o_buck_on,
	input wire logic [3:0] o_buck_soft_start,
	input wire logic [3:0] o_buck_power_good,
	input wire logic o_host_irq_out_n
);
	logic [15:0] ss_cnt_ff;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);
	// Cycles the first buck's ramp has stood
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) ss_cnt_ff <= 16'h0000;
		else ss_cnt_ff <= o_buck_soft_start[0] ? ss_cnt_ff + 16'h0001 : 16'h0000;
	end
	chk_bank_a_take: assert property (i_buck_bank_a_wr[1] && !i_voltage_bank_select_pin[1]
		|=> o_buck_output_voltage_code[11:6] == $past(i_wr_code)) else $error("bank A code");
	chk_bank_b_take: assert property (i_buck_bank_b_wr[2] && i_voltage_bank_select_pin[2]
		|=> o_buck_output_voltage_code[17:12] == $past(i_wr_code)) else $error("bank B code");
	chk_code_max: assert property (o_buck_output_voltage_code[23:18] == 6'h3F
		|-> o_buck_target_mv[51:39] == RGCTL_MV_MAX) else $error("top code voltage");
	chk_enable_copy: assert property ($past(i_arst_n) |-> o_buck_on == $past(i_buck_enable))
		else $error("buck on");
	chk_pg_low: assert property ($past(i_arst_n)
		|-> (o_buck_power_good & ~$past(i_buck_power_good)) == 4'h0) else $error("power good");
	chk_irq_raise: assert property (|(i_fault_irq_unmask & i_buck_enable & ~i_buck_power_good)
		|-> ##2 !o_host_irq_out_n) else $error("irq raise");
	chk_irq_release: assert property ($rose(o_host_irq_out_n)
		|-> $past(i_buck_power_good | ~i_buck_enable | ~i_fault_irq_unmask, 2) == 4'hF) else $error("irq release");
	chk_ss_length: assert property (ss_cnt_ff <= 16'h9C40) else $error("ramp length");
endmodule : rgctl_top_sva

bind rgctl_top rgctl_top_sva chk (.*);

// file: verif/rgctl_host_model.sv
// Host model: writes the code bank matching the select pin and reads
// status while the interrupt is low. Inputs change at the falling edge.
`timescale 1ns/1ps
module rgctl_host_model (
	// Requests from the bench
	input wire logic i_clock,
	input wire logic i_req,
	input wire logic [1:0] i_buck,
	input wire logic [3:0] i_pin,
	input wire logic i_read_en,
	input wire logic i_irq_n,
	// Strobes to the block
	output logic [3:0] o_bank_a_wr,
	output logic [3:0] o_bank_b_wr,
	output logic [3:0] o_status_read
);
	logic read_phase = 1'b0;
	always_comb begin
		o_bank_a_wr = 4'h0;
		o_bank_b_wr = 4'h0;
		if (i_req) begin
			o_bank_a_wr[i_buck] = !i_pin[i_buck];
			o_bank_b_wr[i_buck] = i_pin[i_buck];
		end
	end
	// One-cycle reads, a cycle apart
	always @(negedge i_clock) read_phase <= i_read_en && !i_irq_n && !read_phase;
	assign o_status_read = {4{read_phase}};
endmodule : rgctl_host_model

// file: verif/testbench.sv
// Testbench for the regulator control logic: table of code writes, then
// enables, ramp, fault interrupt and reset. Host writes via the model.
`timescale 1ns/1ps
module testbench
	import rgctl_pkg::*;
;
	typedef struct packed {
		logic [5:0] code;
		logic [12:0] mv;
	} rgctl_row_s;
	rgctl_row_s rows [8] = '{'{6'h00, 13'h0258}, '{6'h0F, 13'h03CF}, '{6'h11, 13'h0401}, '{6'h1A, 13'h0514},
		'{6'h23, 13'h06D6}, '{6'h2D, 13'h08CA}, '{6'h36, 13'h0BB8}, '{6'h3F, 13'h0F3C}};
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic req = 1'b0;
	logic read_en = 1'b0;
	logic [1:0] buck = 2'h0;
	logic [5:0] i_wr_code = 6'h00;
	logic [3:0] i_buck_bank_a_wr, i_buck_bank_b_wr, i_status_read, o_buck_on, o_buck_soft_start, o_buck_power_good;
	logic [3:0] i_buck_enable = 4'h0, i_fault_irq_unmask = 4'h1;
	logic [3:0] i_voltage_bank_select_pin = 4'h0, i_buck_power_good = 4'hF;
	logic [7:0] i_ldo_code_wr = 8'h00, i_ldo_enable = 8'h00, i_output_discharge_enable = 8'h00, o_ldo_on, o_ldo_discharge;
	logic [23:0] o_buck_output_voltage_code;
	logic [51:0] o_buck_target_mv;
	logic [47:0] o_ldo_output_voltage_code;
	logic [103:0] o_ldo_target_mv;
	logic o_host_irq_out_n;
	int n_fail = 0;
	int n_compared = 0;
	rgctl_top dut (.*);
	rgctl_host_model host (.i_clock(i_clock), .i_req(req), .i_buck(buck), .i_pin(i_voltage_bank_select_pin),
		.i_read_en(read_en), .i_irq_n(o_host_irq_out_n), .o_bank_a_wr(i_buck_bank_a_wr),
		.o_bank_b_wr(i_buck_bank_b_wr), .o_status_read(i_status_read));
	initial forever #5 i_clock = ~i_clock;
	task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask : check
	task automatic results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask : tick
	task automatic wait_irq(input logic v);
		for (int k = 0; k < 20 && o_host_irq_out_n !== v; k++) tick(1);
		check("irq", v, o_host_irq_out_n);
		if (o_host_irq_out_n !== v) results();
	endtask : wait_irq
	initial begin
		int ss;
		tick(10);
		i_arst_n = 1'b1;
		tick(1);
		check("buck code", {4{RGCTL_BUCK_DEF_CODE}}, o_buck_output_voltage_code);
		check("ldo code", {8{RGCTL_LDO_DEF_CODE}}, o_ldo_output_voltage_code);
		for (int i = 0; i < 8; i++) begin
			buck = 2'(i % 4);
			i_voltage_bank_select_pin[buck] = i > 4;
			i_wr_code = rows[i].code;
			req = 1'b1;
			i_ldo_code_wr = 8'h01 << i;
			tick(1);
			req = 1'b0;
			i_ldo_code_wr = 8'h00;
			tick(1);
			check("buck code", rows[i].code, o_buck_output_voltage_code[buck*6 +: 6]);
			check("buck mv", rows[i].mv, o_buck_target_mv[buck*13 +: 13]);
			check("ldo code", rows[i].code, o_ldo_output_voltage_code[i*6 +: 6]);
			check("ldo mv", rows[i].mv, o_ldo_target_mv[i*13 +: 13]);
		end
		// Pins low again: bank A values come back
		i_voltage_bank_select_pin = 4'h0;
		tick(2);
		for (int b = 0; b < 4; b++) check("bank A", rows[b == 0 ? 4 : b].code, o_buck_output_voltage_code[b*6 +: 6]);
		i_buck_enable = 4'h5;
		i_ldo_enable = 8'h5A;
		i_output_discharge_enable = 8'h3C;
		tick(2);
		check("buck on", 4'h5, o_buck_on);
		check("ldo on", 8'h5A, o_ldo_on);
		check("discharge", 8'h24, o_ldo_discharge);
		ss = 0;
		for (int i = 0; i < 40100; i++) begin
			if (o_buck_soft_start[0] === 1'b1) ss++;
			tick(1);
		end
		check("ramp", RGCTL_SS_CYCLES, ss);
		i_buck_power_good = 4'hE;
		tick(1);
		check("power good", 4'hE, o_buck_power_good);
		wait_irq(1'b0);
		tick(5);
		i_buck_power_good = 4'hF;
		tick(5);
		check("irq held", 1'b0, o_host_irq_out_n);
		check("ramp restart", 1'b1, o_buck_soft_start[0]);
		read_en = 1'b1;
		wait_irq(1'b1);
		// Masked channel falls out of regulation
		i_buck_power_good = 4'hB;
		tick(5);
		check("masked", 1'b1, o_host_irq_out_n);
		i_buck_power_good = 4'hF;
		i_arst_n = 1'b0;
		tick(2);
		check("buck code", {4{RGCTL_BUCK_DEF_CODE}}, o_buck_output_voltage_code);
		i_arst_n = 1'b1;
		tick(1);
		check("buck on", 4'h5, o_buck_on);
		tick(1);
		check("ramp after reset", 4'h5, o_buck_soft_start);
		check("ldo code", {8{RGCTL_LDO_DEF_CODE}}, o_ldo_output_voltage_code);
		results();
	end
endmodule : testbench
